// ==== scaler_defines.svh ====
`ifndef SCALER_DEFINES_SVH
`define SCALER_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_QUEUE_HALFWORD0   30'h01FF8070
`define IDX_QUEUE_HALFWORD1   30'h01FF8072
`define IDX_QUEUE_HALFWORD2   30'h01FF8074
`define IDX_QUEUE_HALFWORD3   30'h01FF8076
`define IDX_HOLDING_WORD      30'h01FF8078
`define IDX_QUEUE_CONTROL     30'h01FF807A
`define IDX_SCALER_CONTROL    30'h01FF8060
`define IDX_SCALING_RATIO     30'h01FF8062
`define IDX_FAX_CODEC_CONFIG  30'h01FF8064
`define IDX_FAX_CODEC_CONTROL 30'h01FF8066

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTL_OR_BIT       0
`define CTL_START_BIT    1
`define CTL_SOURCE_BIT   2
`define FCFG_CONV_BIT    5
`define FCTL_OR_BIT      3
`define QC_ENABLED_BIT   15
`define QC_REQUEST_BIT   14
`define QC_READY_BIT     13
`define QC_THR_HI        12
`define QC_THR_LO        10
`define QC_OUTPTR_HI     9
`define QC_OUTPTR_LO     8
`define QC_HOLDFULL_BIT  6
`define QC_COUNT_HI      4
`define QC_COUNT_LO      2
`define QC_INPTR_HI      1
`define QC_INPTR_LO      0
`define RATIO_DIR_BIT    15
`define RATIO_COUNT_HI   11

// ----------------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------------
`define QUEUE_DEPTH      3'h4
`define RATIO_PERIOD     12'h88B
`define RATIO_RESET      16'h0000
`define HALFWORD_RESET   16'h0000

`endif

// ==== scaler_pkg.sv ====
package scaler_pkg;

    // Full state of the input side, registered as one word
    typedef struct packed {
        logic              src_ext;
        logic              start_bit;
        logic              start_armed;
        logic              conv_start;
        logic              vert_or;
        logic [15:0]       ratio;
        logic              fcfg_conv;
        logic              fctl_or;
        logic [2:0]        thr;
        logic [1:0]        inptr;
        logic [1:0]        outptr;
        logic [2:0]        count;
        logic [15:0]       hold;
        logic              hold_full;
        logic [3:0][15:0]  entries;
        logic [15:0]       out_data;
        logic [31:0]       prdata;
    } scaler_state_t;

    // Settings handed to the converter datapath
    typedef struct packed {
        logic              src_ext;
        logic              conv_start;
        logic              vert_or;
        logic              post_or;
        logic              dec_conv;
        logic              dec_or;
        logic              ratio_expand;
        logic [11:0]       ratio_count;
    } conv_ctrl_t;

endpackage

// ==== scaler_input_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scaler_defines.svh"

module scaler_input_fifo (
    input  wire logic                     mclk,
    input  wire logic                     reset,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // DMA channel side
    output logic                          dma_req,
    input  wire logic                     dma_wr,
    input  wire logic [15:0]              dma_wdata,
    // Converter side
    input  wire logic                     conv_rd,
    output logic                          conv_valid,
    output logic      [15:0]              conv_data,
    output scaler_pkg::conv_ctrl_t        conv_ctrl
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    scaler_pkg::scaler_state_t state_reg;
    scaler_pkg::scaler_state_t state_next;

    logic [2:0]  thr_eff;
    logic        enabled;
    logic        ready;
    logic        req;
    logic [29:0] word_idx;
    logic        aligned;
    logic        setup;
    logic        access_wr;
    logic        hit;
    logic [15:0] qc_read;

    // ------------------------------------------------------------------
    // Queue status decode
    // ------------------------------------------------------------------
    // Out-of-range thresholds are folded here so the compare stays simple
    assign thr_eff = (state_reg.thr > `QUEUE_DEPTH) ? `QUEUE_DEPTH
                                                    : state_reg.thr;
    // The queue runs only while memory is the chosen source
    assign enabled = state_reg.src_ext;
    // Data flows into local logic, so only an empty queue blocks it
    assign ready   = (state_reg.count != 3'h0);
    // Holding register must be free, or the DMA word would be dropped
    assign req     = enabled && !state_reg.hold_full
                     && (state_reg.count <= thr_eff);

    // Control register read image
    always_comb begin
        qc_read = 16'h0000;
        qc_read[`QC_ENABLED_BIT]              = enabled;
        qc_read[`QC_REQUEST_BIT]              = req;
        qc_read[`QC_READY_BIT]                = ready;
        qc_read[`QC_THR_HI:`QC_THR_LO]        = state_reg.thr;
        qc_read[`QC_OUTPTR_HI:`QC_OUTPTR_LO]  = state_reg.outptr;
        qc_read[`QC_HOLDFULL_BIT]             = state_reg.hold_full;
        qc_read[`QC_COUNT_HI:`QC_COUNT_LO]    = state_reg.count;
        qc_read[`QC_INPTR_HI:`QC_INPTR_LO]    = state_reg.inptr;
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    assign word_idx  = paddr[31:2];
    assign aligned   = (paddr[1:0] == 2'h0);
    assign setup     = psel && !penable;
    assign access_wr = psel && penable && pwrite && hit;

    // Address hit test shared by access write and error response
    always_comb begin
        case (word_idx)
            `IDX_QUEUE_HALFWORD0,
            `IDX_QUEUE_HALFWORD1,
            `IDX_QUEUE_HALFWORD2,
            `IDX_QUEUE_HALFWORD3,
            `IDX_HOLDING_WORD,
            `IDX_QUEUE_CONTROL,
            `IDX_SCALER_CONTROL,
            `IDX_SCALING_RATIO,
            `IDX_FAX_CODEC_CONFIG,
            `IDX_FAX_CODEC_CONTROL: hit = aligned;
            default:                hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic       push;
        logic       pop;
        logic [2:0] cnt;
        state_next = state_reg;
        push = 1'b0;
        pop  = 1'b0;
        cnt  = state_reg.count;
        state_next.conv_start = 1'b0;

        // Converter takes the head entry
        if (conv_rd && ready) begin
            pop = 1'b1;
            state_next.outptr = state_reg.outptr + 2'h1;
        end

        // Full holding word moves into the queue while there is room
        if (state_reg.hold_full && (state_reg.count != `QUEUE_DEPTH)) begin
            push = 1'b1;
            state_next.entries[state_reg.inptr] = state_reg.hold;
            state_next.inptr = state_reg.inptr + 2'h1;
            state_next.hold_full = 1'b0;
        end

        // DMA word lands in the holding register once it is free
        if (dma_wr && enabled && (!state_reg.hold_full || push)) begin
            state_next.hold      = dma_wdata;
            state_next.hold_full = 1'b1;
        end

        // Filled count follows pushes and pops, never beyond four
        case ({push, pop})
            2'b10:   cnt = state_reg.count + 3'h1;
            2'b01:   cnt = state_reg.count - 3'h1;
            default: cnt = state_reg.count;
        endcase
        state_next.count = cnt;

        // Register writes at the access edge
        if (access_wr) begin
            case (word_idx)
                `IDX_QUEUE_HALFWORD0:
                    state_next.entries[0] = pwdata[15:0];
                `IDX_QUEUE_HALFWORD1:
                    state_next.entries[1] = pwdata[15:0];
                `IDX_QUEUE_HALFWORD2:
                    state_next.entries[2] = pwdata[15:0];
                `IDX_QUEUE_HALFWORD3:
                    state_next.entries[3] = pwdata[15:0];
                `IDX_HOLDING_WORD: begin
                    state_next.hold = pwdata[15:0];
                end
                `IDX_QUEUE_CONTROL: begin
                    // Pointers are overwritten as given; a live queue
                    // may be corrupted, so software stops it first
                    state_next.thr    = pwdata[`QC_THR_HI:`QC_THR_LO];
                    state_next.outptr = pwdata[`QC_OUTPTR_HI:`QC_OUTPTR_LO];
                    state_next.hold_full = pwdata[`QC_HOLDFULL_BIT];
                    state_next.count  = pwdata[`QC_COUNT_HI:`QC_COUNT_LO];
                    state_next.inptr  = pwdata[`QC_INPTR_HI:`QC_INPTR_LO];
                    if (pwdata[`QC_COUNT_HI:`QC_COUNT_LO] > `QUEUE_DEPTH) begin
                        state_next.count = `QUEUE_DEPTH;
                    end
                end
                `IDX_SCALER_CONTROL: begin
                    state_next.vert_or   = pwdata[`CTL_OR_BIT];
                    state_next.start_bit = pwdata[`CTL_START_BIT];
                    state_next.src_ext   = pwdata[`CTL_SOURCE_BIT];
                    // Start needs the high then low sequence
                    if (pwdata[`CTL_START_BIT]) begin
                        state_next.start_armed = 1'b1;
                    end else if (state_reg.start_armed) begin
                        state_next.start_armed = 1'b0;
                        state_next.conv_start  = 1'b1;
                    end
                end
                `IDX_SCALING_RATIO: begin
                    state_next.ratio = pwdata[15:0];
                end
                `IDX_FAX_CODEC_CONFIG: begin
                    state_next.fcfg_conv = pwdata[`FCFG_CONV_BIT];
                end
                `IDX_FAX_CODEC_CONTROL: begin
                    state_next.fctl_or = pwdata[`FCTL_OR_BIT];
                end
                default: begin
                end
            endcase
        end

        // Read data captured in the setup phase, held through access
        if (setup) begin
            state_next.prdata = 32'h0000_0000;
            case (word_idx)
                `IDX_QUEUE_HALFWORD0:
                    state_next.prdata[15:0] = state_reg.entries[0];
                `IDX_QUEUE_HALFWORD1:
                    state_next.prdata[15:0] = state_reg.entries[1];
                `IDX_QUEUE_HALFWORD2:
                    state_next.prdata[15:0] = state_reg.entries[2];
                `IDX_QUEUE_HALFWORD3:
                    state_next.prdata[15:0] = state_reg.entries[3];
                `IDX_HOLDING_WORD:
                    state_next.prdata[15:0] = state_reg.hold;
                `IDX_QUEUE_CONTROL:
                    state_next.prdata[15:0] = qc_read;
                `IDX_SCALER_CONTROL: begin
                    state_next.prdata[`CTL_OR_BIT]     = state_reg.vert_or;
                    state_next.prdata[`CTL_START_BIT]  = state_reg.start_bit;
                    state_next.prdata[`CTL_SOURCE_BIT] = state_reg.src_ext;
                end
                `IDX_SCALING_RATIO:
                    state_next.prdata[15:0] = state_reg.ratio;
                `IDX_FAX_CODEC_CONFIG:
                    state_next.prdata[`FCFG_CONV_BIT] = state_reg.fcfg_conv;
                `IDX_FAX_CODEC_CONTROL:
                    state_next.prdata[`FCTL_OR_BIT] = state_reg.fctl_or;
                default: begin
                end
            endcase
            if (!aligned) begin
                state_next.prdata = 32'h0000_0000;
            end
        end

        // Head data prepared one cycle ahead for the converter
        state_next.out_data = state_next.entries[state_next.outptr];
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset clears everything, the ratio register included
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Zero wait states: the read word was latched during setup
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !hit;
    assign prdata     = state_reg.prdata;
    assign dma_req    = req;
    assign conv_valid = ready;
    assign conv_data  = state_reg.out_data;

    // Datapath settings; decoder ORing is void without decoder scaling
    always_comb begin
        conv_ctrl              = '0;
        conv_ctrl.src_ext      = state_reg.src_ext;
        conv_ctrl.conv_start   = state_reg.conv_start;
        conv_ctrl.vert_or      = state_reg.vert_or;
        conv_ctrl.post_or      = state_reg.vert_or;
        conv_ctrl.dec_conv     = state_reg.fcfg_conv;
        conv_ctrl.dec_or       = state_reg.fctl_or
                                 && state_reg.fcfg_conv;
        conv_ctrl.ratio_expand = state_reg.ratio[`RATIO_DIR_BIT];
        conv_ctrl.ratio_count  = state_reg.ratio[`RATIO_COUNT_HI:0];
    end

endmodule // scaler_input_fifo

`default_nettype wire

// ==== dma_channel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// DMA channel feeding the input queue from memory
// ------------------------------------------------
module dma_channel_model (
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        go,
    input  wire logic        dma_req,
    output logic             dma_wr,
    output logic      [15:0] dma_wdata
);
    logic [15:0] next_word_reg;

    // One halfword per request, then a gap so the request can settle
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            dma_wr        <= 1'b0;
            dma_wdata     <= 16'hFFFF;
            next_word_reg <= 16'hA000;
        end else if (go && dma_req && !dma_wr) begin
            dma_wr        <= 1'b1;
            dma_wdata     <= next_word_reg;
            next_word_reg <= next_word_reg + 16'h0001;
        end else begin
            dma_wr        <= 1'b0;
            dma_wdata     <= ~dma_wdata; // Idle bus inverts every cycle, so the last word shows every other cycle
        end
    end
endmodule // dma_channel_model
`default_nettype wire

// ==== scaler_input_fifo_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scaler_defines.svh"
// ------------------------------------------------
// Port checker for the scaler input queue
// ------------------------------------------------
module scaler_input_fifo_chk (
    input wire logic                   mclk,
    input wire logic                   reset,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic            [31:0] paddr,
    input wire logic            [31:0] pwdata,
    input wire logic            [31:0] prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   dma_req,
    input wire logic                   dma_wr,
    input wire logic            [15:0] dma_wdata,
    input wire logic                   conv_rd,
    input wire logic                   conv_valid,
    input wire logic            [15:0] conv_data,
    input wire scaler_pkg::conv_ctrl_t conv_ctrl
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // Access phases that matter to the start and error checks
    wire logic ctl_wr0 = psel && penable && pwrite && !pwdata[1]
                         && (paddr == {`IDX_SCALER_CONTROL, 2'b00});
    wire logic ratio_acc = psel && penable
                           && (paddr == {`IDX_SCALING_RATIO, 2'b00});

    chk_zero_wait: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
    chk_err_phase: assert property (pslverr |-> psel && penable)
        else $error("error outside access phase");
    chk_mapped_ok: assert property (ratio_acc |-> !pslverr)
        else $error("error on mapped register");
    chk_req_enable: assert property (dma_req |-> conv_ctrl.src_ext)
        else $error("request while queue disabled");
    chk_req_drop: assert property (dma_wr && dma_req |=> !dma_req)
        else $error("request kept with holding full");
    chk_start_once: assert property ($rose(conv_ctrl.conv_start)
        |=> !conv_ctrl.conv_start)
        else $error("start longer than one cycle");
    chk_start_cause: assert property (conv_ctrl.conv_start
        |-> $past(ctl_wr0) || $past(ctl_wr0, 2))
        else $error("start without clearing write");
    chk_post_or: assert property (conv_ctrl.post_or == conv_ctrl.vert_or)
        else $error("final ORing differs from enable");
    chk_dec_gate: assert property (conv_ctrl.dec_or |-> conv_ctrl.dec_conv)
        else $error("decoder ORing without conversion");
    chk_ratio_clear: assert property ($fell(reset)
        |-> conv_ctrl.ratio_count == 12'h000 && !conv_ctrl.ratio_expand)
        else $error("ratio not cleared by reset");
endmodule // scaler_input_fifo_chk

bind scaler_input_fifo scaler_input_fifo_chk u_scaler_input_fifo_chk (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dma_req(dma_req), .dma_wr(dma_wr),
    .dma_wdata(dma_wdata), .conv_rd(conv_rd), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_ctrl(conv_ctrl));
`default_nettype wire

// ==== bilevel_scaler_input_fifo_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "scaler_defines.svh"
// ------------------------------------------------
// Self-checking bench for the scaler input queue
// ------------------------------------------------
module bilevel_scaler_input_fifo_bench;
    logic                   mclk = 1'b0;
    logic                   reset, psel, penable, pwrite, pready, pslverr;
    logic            [31:0] paddr, pwdata, prdata, rd, n;
    logic                   dma_req, dma_wr, conv_rd, conv_valid, go, err;
    logic            [15:0] dma_wdata, conv_data, exp_word;
    scaler_pkg::conv_ctrl_t conv_ctrl;
    int                     mismatches = 0, num_checks = 0;

    always #2.5 mclk = ~mclk;

    scaler_input_fifo u_scaler_input_fifo (.mclk(mclk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dma_req(dma_req), .dma_wr(dma_wr),
        .dma_wdata(dma_wdata), .conv_rd(conv_rd), .conv_valid(conv_valid),
        .conv_data(conv_data), .conv_ctrl(conv_ctrl));
    dma_channel_model u_dma_channel_model (.mclk(mclk), .reset(reset),
        .go(go), .dma_req(dma_req), .dma_wr(dma_wr), .dma_wdata(dma_wdata));

    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task timeout;
        mismatches++;
        $display("wait ran out at %0t", $time);
        print_verdict();
    endtask
    // APB cycle: setup, access held until ready is sampled high
    task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) timeout();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [29:0] idx, input logic [31:0] d);
        apb(1'b1, {idx, 2'b00}, d);
    endtask
    task rdc(input logic [29:0] idx, input logic [31:0] e);
        apb(1'b0, {idx, 2'b00}, 32'h0);
        check({err, rd[30:0]}, e);
    endtask
    // Pop one halfword, checking the head before the pop edge
    task pop;
        @(posedge mclk);
        check({conv_valid, conv_data}, {1'b1, exp_word});
        exp_word = exp_word + 16'h0001;
        conv_rd <= 1'b1;
        @(posedge mclk);
        conv_rd <= 1'b0;
    endtask
    // Let the channel run until its request stays low
    task fill;
        int i, k;
        k = 0;
        go <= 1'b1;
        for (i = 0; i < 200 && k < 4; i++) begin
            @(posedge mclk);
            k = (dma_req === 1'b0) ? k + 1 : 0;
        end
        if (k < 4) timeout();
        go <= 1'b0;
    endtask

    task t_reset;
        logic [29:0] ids [7];
        ids = '{`IDX_QUEUE_HALFWORD0, `IDX_QUEUE_HALFWORD1,
                `IDX_QUEUE_HALFWORD2, `IDX_QUEUE_HALFWORD3,
                `IDX_HOLDING_WORD, `IDX_QUEUE_CONTROL, `IDX_SCALING_RATIO};
        foreach (ids[i]) rdc(ids[i], 32'h0);
    endtask
    task t_refuse;
        apb(1'b0, {30'h01FF8068, 2'b00}, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        apb(1'b1, {`IDX_SCALING_RATIO, 2'b10}, 32'h1234);
        check(err, 1'b1);
        rdc(`IDX_SCALING_RATIO, 32'h0);
    endtask
    task t_regs;
        wr(`IDX_SCALING_RATIO, 32'h8123);
        rdc(`IDX_SCALING_RATIO, 32'h8123);
        check({conv_ctrl.ratio_expand, conv_ctrl.ratio_count}, 13'h1123);
        wr(`IDX_FAX_CODEC_CONFIG, 32'h20);
        wr(`IDX_FAX_CODEC_CONTROL, 32'h08);
        @(posedge mclk);
        check({conv_ctrl.dec_conv, conv_ctrl.dec_or}, 2'b11);
        rdc(`IDX_FAX_CODEC_CONFIG, 32'h20);
        wr(`IDX_FAX_CODEC_CONFIG, 32'h00);
        @(posedge mclk);
        check({conv_ctrl.dec_conv, conv_ctrl.dec_or}, 2'b00);
        rdc(`IDX_FAX_CODEC_CONTROL, 32'h8);
        wr(`IDX_QUEUE_HALFWORD2, 32'h5A5A);
        rdc(`IDX_QUEUE_HALFWORD2, 32'h5A5A);
    endtask
    // Start fires only after the bit goes high and back low
    task t_start;
        n = 0;
        wr(`IDX_SCALER_CONTROL, 32'h3);
        repeat (4) @(posedge mclk) n = n + conv_ctrl.conv_start;
        check(n, 32'h0);
        wr(`IDX_SCALER_CONTROL, 32'h1);
        repeat (6) @(posedge mclk) n = n + conv_ctrl.conv_start;
        check(n, 32'h1);
        check({conv_ctrl.src_ext, conv_ctrl.vert_or, conv_ctrl.post_or},
              3'b011);
        rdc(`IDX_SCALER_CONTROL, 32'h1);
    endtask
    // Fill to threshold 2, drain, refill across the pointer wrap
    task t_flow;
        wr(`IDX_SCALER_CONTROL, 32'h0);
        wr(`IDX_QUEUE_CONTROL, 32'h0800);
        wr(`IDX_SCALER_CONTROL, 32'h4);
        // Settings appear at the access edge that writes them; one more edge is waited
        @(posedge mclk);
        check(conv_ctrl.src_ext, 1'b1);
        fill();
        check(conv_ctrl.src_ext, 1'b1);
        rdc(`IDX_QUEUE_CONTROL, 32'hA80F);
        repeat (3) pop();
        rdc(`IDX_QUEUE_CONTROL, 32'hCB03);
        fill();
        rdc(`IDX_QUEUE_CONTROL, 32'hAB0E);
        repeat (3) pop();
    endtask
    // Threshold above four acts as four; last word waits in holding
    task t_clamp;
        wr(`IDX_SCALER_CONTROL, 32'h0);
        wr(`IDX_QUEUE_CONTROL, 32'h1C00);
        wr(`IDX_SCALER_CONTROL, 32'h4);
        fill();
        apb(1'b0, {`IDX_QUEUE_CONTROL, 2'b00}, 32'h0);
        check(rd & 32'hFFFFE3FF, 32'hA050);
        rdc(`IDX_HOLDING_WORD, exp_word + 32'h4);
        repeat (5) pop();
    endtask

    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        conv_rd = 1'b0;
        go = 1'b0;
        exp_word = 16'hA000;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_refuse();
        t_regs();
        t_start();
        t_flow();
        t_clamp();
        print_verdict();
    end
endmodule // bilevel_scaler_input_fifo_bench
`default_nettype wire
